// ==== core/lsrr_pkg.sv ====
package lsrr_pkg;

    // Command codes of the registers held here
    localparam logic [7:0] CMD_LOW_LIMIT = 8'h02;
    localparam logic [7:0] CMD_PS_CTRL = 8'h03;
    localparam logic [7:0] CMD_LIGHT = 8'h04;
    localparam logic [7:0] CMD_BROAD = 8'h05;

    // Power-saving control word fields
    localparam int PS_EN_BIT = 0;
    localparam int PS_SEL_LSB = 1;
    localparam int PS_SEL_MSB = 2;

    // Interrupt status word: low-window flag position
    localparam int FLAG_BIT = 15;

    // Reset values
    localparam logic [15:0] LOW_LIMIT_RST = 16'h0000;
    localparam logic [1:0] PS_SEL_RST = 2'h0;
    localparam logic PS_EN_RST = 1'b0;
    localparam logic [15:0] RESULT_RST = 16'h0000;
    localparam logic [7:0] CMD_RST = 8'h00;

    // Serial port framing
    localparam logic RW_READ = 1'b1;

    // Spike suppression on the serial lines
    localparam int CLK_MHZ = 250;
    localparam int SPIKE_NS = 50;
    localparam int SPIKE_CYC = (SPIKE_NS * CLK_MHZ + 999) / 1000;
    localparam int SPIKE_W = 4;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_WDATA,
        ST_RDATA,
        ST_ACK,
        ST_MACK
    } lsrr_state_t;

endpackage

// ==== core/lsrr_sync.sv ====
`timescale 1ns/1ns
module lsrr_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Lines
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // Idle level of an open-drain line is high
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule

// ==== core/lsrr_top.sv ====
`timescale 1ns/1ns
// Function
// R01 - Writable 16-bit low window limit at 02h
// R02 - Low limit upper byte 15:8, lower 7:0
// R03 - Bits 2:1 at 03h select mode 1 to 4
// R04 - Bit 0 at 03h enables power saving
// R05 - Host writes reserved bits 15:3 as zero
// R06 - Ambient light result readable at 04h
// R07 - Ambient result MSB 15:8, LSB 7:0
// R08 - Broadband result readable at 05h
// R09 - Broadband result upper 15:8, lower 7:0
// R10 - Crossing below low limit sets flag bit 15
// R11 - Every command code is a 16-bit register
// R12 - Results update together, reads never mix measurements
module lsrr_top #(
    parameter logic [6:0] SLAVE_ADDR = 7'h48
) (
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    // Serial host port
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_O,
    // Measurement engine
    input wire logic MEAS_VALID_I,
    input wire logic [15:0] AMBIENT_LIGHT_RESULT_I,
    input wire logic [15:0] BROADBAND_RESULT_I,
    // Interrupt logic
    input wire logic INT_ENABLE_I,
    input wire logic FLAG_CLEAR_I,
    output logic [15:0] INT_STATUS_O,
    // Settings
    output logic [15:0] LOW_WINDOW_LIMIT_O,
    output logic [1:0] POWER_SAVING_SELECT_O,
    output logic POWER_SAVING_ENABLE_O
);

    // Line conditioning
    logic [1:0] line_sync;
    logic [1:0] line_flt_q;
    logic [1:0] line_dly_q;
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    // Protocol engine
    lsrr_pkg::lsrr_state_t state_q;
    lsrr_pkg::lsrr_state_t state_d;
    lsrr_pkg::lsrr_state_t after_q;
    lsrr_pkg::lsrr_state_t after_d;
    logic [7:0] sh_q;
    logic [7:0] sh_d;
    logic [7:0] tx_q;
    logic [7:0] tx_d;
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic full_q;
    logic full_d;
    logic oe_q;
    logic oe_d;
    logic mack_q;
    logic mack_d;
    logic hi_sel_q;
    logic hi_sel_d;
    logic [7:0] cmd_q;
    logic [7:0] cmd_d;
    logic [7:0] lo_byte_q;
    logic [7:0] lo_byte_d;
    logic [15:0] shadow_q;
    logic [15:0] shadow_d;
    logic wr_stb;
    logic [15:0] wr_word;

    // Register file
    logic [15:0] low_limit_q;
    logic [1:0] power_saving_select_q;
    logic power_saving_enable_q;
    logic [15:0] light_q;
    logic [15:0] broad_q;
    logic below_window_flag_q;
    logic sda_o_q;

    // Decode
    logic addr_hit;
    logic wr_low;
    logic wr_ps;
    logic [15:0] rd_word;
    logic [7:0] next_byte;
    logic cross_below;
    logic flag_d;

    lsrr_sync #(
        .W(2)
    ) u_sync (
        .clk_i(CORE_CLK_I),
        .rst_i(RST_I),
        .async_i({SDA_I, SCL_I}),
        .sync_o(line_sync)
    );

    // A line level is taken only after it has held for the spike time
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_flt
            logic [lsrr_pkg::SPIKE_W-1:0] stable_q;
            always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
                if (RST_I) begin
                    stable_q <= '0;
                    line_flt_q[gi] <= 1'b1;
                end else if (line_sync[gi] == line_flt_q[gi]) begin
                    stable_q <= '0;
                end else if (stable_q == lsrr_pkg::SPIKE_W'(lsrr_pkg::SPIKE_CYC - 1)) begin
                    stable_q <= '0;
                    line_flt_q[gi] <= line_sync[gi];
                end else begin
                    stable_q <= stable_q + 1'b1;
                end
            end
        end
    endgenerate

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            line_dly_q <= 2'h3;
        end else begin
            line_dly_q <= line_flt_q;
        end
    end

    assign scl_s = line_flt_q[0];
    assign sda_s = line_flt_q[1];
    assign scl_rise = scl_s & ~line_dly_q[0];
    assign scl_fall = ~scl_s & line_dly_q[0];
    assign start_det = scl_s & line_dly_q[0] & ~sda_s & line_dly_q[1];
    assign stop_det = scl_s & line_dly_q[0] & sda_s & ~line_dly_q[1];

    assign addr_hit = (sh_q[7:1] == SLAVE_ADDR);
    assign wr_word = {sh_q, lo_byte_q}; // [R02]
    assign wr_low = wr_stb & (cmd_q == lsrr_pkg::CMD_LOW_LIMIT); // [R01]
    assign wr_ps = wr_stb & (cmd_q == lsrr_pkg::CMD_PS_CTRL);

    // Write-only and unknown codes read back as zero
    assign rd_word = (cmd_q == lsrr_pkg::CMD_LIGHT) ? light_q : // [R06]
                     (cmd_q == lsrr_pkg::CMD_BROAD) ? broad_q : // [R08]
                     16'h0000;
    // Low byte goes first, then high byte, repeating
    assign next_byte = hi_sel_q ? shadow_q[7:0] : shadow_q[15:8]; // [R07] [R09]

    always_comb begin
        state_d = state_q;
        after_d = after_q;
        sh_d = sh_q;
        tx_d = tx_q;
        cnt_d = cnt_q;
        full_d = full_q;
        oe_d = oe_q;
        mack_d = mack_q;
        hi_sel_d = hi_sel_q;
        cmd_d = cmd_q;
        lo_byte_d = lo_byte_q;
        shadow_d = shadow_q;
        wr_stb = 1'b0;
        if (stop_det) begin
            state_d = lsrr_pkg::ST_IDLE;
            oe_d = 1'b0;
        end else if (start_det) begin
            state_d = lsrr_pkg::ST_ADDR;
            cnt_d = 3'h0;
            full_d = 1'b0;
            oe_d = 1'b0;
        end else if (scl_rise) begin
            case (state_q)
                lsrr_pkg::ST_ADDR, lsrr_pkg::ST_CMD, lsrr_pkg::ST_WDATA: begin
                    sh_d = {sh_q[6:0], sda_s};
                    cnt_d = cnt_q + 3'h1;
                    full_d = (cnt_q == 3'h7);
                end
                lsrr_pkg::ST_RDATA: begin
                    cnt_d = cnt_q + 3'h1;
                    full_d = (cnt_q == 3'h7);
                end
                lsrr_pkg::ST_MACK: begin
                    mack_d = ~sda_s;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (state_q)
                lsrr_pkg::ST_ADDR: begin
                    if (full_q) begin
                        full_d = 1'b0;
                        if (addr_hit) begin
                            oe_d = 1'b1;
                            state_d = lsrr_pkg::ST_ACK;
                            hi_sel_d = 1'b0;
                            if (sh_q[0] == lsrr_pkg::RW_READ) begin
                                after_d = lsrr_pkg::ST_RDATA;
                                shadow_d = rd_word; // [R12]
                            end else begin
                                after_d = lsrr_pkg::ST_CMD;
                            end
                        end else begin
                            state_d = lsrr_pkg::ST_IDLE;
                        end
                    end
                end
                lsrr_pkg::ST_CMD: begin
                    if (full_q) begin
                        full_d = 1'b0;
                        cmd_d = sh_q;
                        hi_sel_d = 1'b0;
                        oe_d = 1'b1;
                        state_d = lsrr_pkg::ST_ACK;
                        after_d = lsrr_pkg::ST_WDATA;
                    end
                end
                lsrr_pkg::ST_WDATA: begin
                    if (full_q) begin
                        full_d = 1'b0;
                        oe_d = 1'b1;
                        state_d = lsrr_pkg::ST_ACK;
                        after_d = lsrr_pkg::ST_WDATA;
                        hi_sel_d = ~hi_sel_q;
                        // Word commits whole on its high byte
                        if (hi_sel_q) begin
                            wr_stb = 1'b1; // [R11]
                        end else begin
                            lo_byte_d = sh_q;
                        end
                    end
                end
                lsrr_pkg::ST_ACK: begin
                    state_d = after_q;
                    if (after_q == lsrr_pkg::ST_RDATA) begin
                        oe_d = ~shadow_q[7];
                        tx_d = {shadow_q[6:0], 1'b0};
                    end else begin
                        oe_d = 1'b0;
                    end
                end
                lsrr_pkg::ST_RDATA: begin
                    if (full_q) begin
                        full_d = 1'b0;
                        oe_d = 1'b0;
                        state_d = lsrr_pkg::ST_MACK;
                    end else begin
                        oe_d = ~tx_q[7];
                        tx_d = {tx_q[6:0], 1'b0};
                    end
                end
                lsrr_pkg::ST_MACK: begin
                    if (mack_q) begin
                        hi_sel_d = ~hi_sel_q;
                        oe_d = ~next_byte[7];
                        tx_d = {next_byte[6:0], 1'b0};
                        state_d = lsrr_pkg::ST_RDATA;
                    end else begin
                        state_d = lsrr_pkg::ST_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_q <= lsrr_pkg::ST_IDLE;
            after_q <= lsrr_pkg::ST_IDLE;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            cnt_q <= 3'h0;
            full_q <= 1'b0;
            oe_q <= 1'b0;
            mack_q <= 1'b0;
            hi_sel_q <= 1'b0;
            cmd_q <= lsrr_pkg::CMD_RST;
            lo_byte_q <= 8'h00;
            shadow_q <= lsrr_pkg::RESULT_RST;
        end else begin
            state_q <= state_d;
            after_q <= after_d;
            sh_q <= sh_d;
            tx_q <= tx_d;
            cnt_q <= cnt_d;
            full_q <= full_d;
            oe_q <= oe_d;
            mack_q <= mack_d;
            hi_sel_q <= hi_sel_d;
            cmd_q <= cmd_d;
            lo_byte_q <= lo_byte_d;
            shadow_q <= shadow_d;
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            low_limit_q <= lsrr_pkg::LOW_LIMIT_RST;
        end else if (wr_low) begin
            low_limit_q <= wr_word; // [R01] [R02]
        end
    end

    // Reserved bits 15:3 are not stored
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            power_saving_select_q <= lsrr_pkg::PS_SEL_RST;
            power_saving_enable_q <= lsrr_pkg::PS_EN_RST;
        end else if (wr_ps) begin
            power_saving_select_q <= wr_word[lsrr_pkg::PS_SEL_MSB:lsrr_pkg::PS_SEL_LSB]; // [R03]
            power_saving_enable_q <= wr_word[lsrr_pkg::PS_EN_BIT]; // [R04]
        end
    end

    // Both results take the same measurement in one edge
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            light_q <= lsrr_pkg::RESULT_RST;
            broad_q <= lsrr_pkg::RESULT_RST;
        end else if (MEAS_VALID_I) begin
            light_q <= AMBIENT_LIGHT_RESULT_I; // [R12]
            broad_q <= BROADBAND_RESULT_I; // [R12]
        end
    end

    // A new result below the limit after one at or above it
    assign cross_below = MEAS_VALID_I & INT_ENABLE_I & (light_q >= low_limit_q)
                         & (AMBIENT_LIGHT_RESULT_I < low_limit_q); // [R10]
    // Set wins over a clear in the same cycle
    assign flag_d = cross_below | (below_window_flag_q & ~FLAG_CLEAR_I); // [R10]

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            below_window_flag_q <= 1'b0;
            sda_o_q <= 1'b0;
        end else begin
            below_window_flag_q <= flag_d;
            sda_o_q <= 1'b0;
        end
    end

    assign SDA_O = sda_o_q;
    assign SDA_OE_O = oe_q;
    assign INT_STATUS_O = 16'(below_window_flag_q) << lsrr_pkg::FLAG_BIT; // [R10]
    assign LOW_WINDOW_LIMIT_O = low_limit_q;
    assign POWER_SAVING_SELECT_O = power_saving_select_q;
    assign POWER_SAVING_ENABLE_O = power_saving_enable_q;

endmodule

// ==== verification/lsrr_host.sv ====
`timescale 1ns/1ns
module lsrr_host #(
    parameter int HALF = 100,
    parameter logic [6:0] ADDR = 7'h48
) (
    // Clock
    input wire logic clk_i,
    // Serial lines
    input wire logic sda_oe_i,
    output logic scl_o,
    output logic sda_o
);
    logic drv_low = 1'b0;
    int nak = 0;
    event latched;
    // Pulled-up wire, low while either side pulls it
    assign sda_o = !(drv_low || sda_oe_i);
    initial scl_o = 1'b1;
    task automatic hp();
        repeat (HALF) @(negedge clk_i);
    endtask
    // Data moves a quarter of a half period after the fall, clear of the clock edge
    task automatic bitx(input logic b, output logic r);
        repeat (HALF / 4) @(negedge clk_i);
        drv_low = !b;
        hp();
        scl_o = 1'b1;
        hp();
        r = sda_o;
        scl_o = 1'b0;
    endtask
    task automatic start();
        drv_low = 1'b0;
        hp();
        scl_o = 1'b1;
        hp();
        drv_low = 1'b1;
        hp();
        scl_o = 1'b0;
    endtask
    task automatic stop();
        repeat (HALF / 4) @(negedge clk_i);
        drv_low = 1'b1;
        hp();
        scl_o = 1'b1;
        hp();
        drv_low = 1'b0;
        hp();
    endtask
    task automatic wbyte(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], r);
        end
        bitx(1'b1, r);
        // An unknown level on the ack bit counts as a missing ack
        if (r !== 1'b0) begin
            nak++;
        end
    endtask
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            d[i] = r;
        end
        bitx(last, r);
    endtask
    task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
        start();
        wbyte({ADDR, 1'b0});
        wbyte(cmd);
        wbyte(d[7:0]);
        wbyte(d[15:8]);
        stop();
    endtask
    task automatic rd(input logic [7:0] cmd, output logic [15:0] d);
        start();
        wbyte({ADDR, 1'b0});
        wbyte(cmd);
        start();
        wbyte({ADDR, 1'b1});
        -> latched;
        rbyte(1'b0, d[7:0]);
        rbyte(1'b1, d[15:8]);
        stop();
    endtask
endmodule

// ==== verification/lsrr_top_sva.sv ====
`timescale 1ns/1ns
module lsrr_top_sva (
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    // Serial host port
    input wire logic SCL_I,
    input wire logic SDA_I,
    input wire logic SDA_O,
    input wire logic SDA_OE_O,
    // Measurement engine
    input wire logic MEAS_VALID_I,
    input wire logic [15:0] AMBIENT_LIGHT_RESULT_I,
    input wire logic [15:0] BROADBAND_RESULT_I,
    // Interrupt logic
    input wire logic INT_ENABLE_I,
    input wire logic FLAG_CLEAR_I,
    input wire logic [15:0] INT_STATUS_O,
    // Settings
    input wire logic [15:0] LOW_WINDOW_LIMIT_O,
    input wire logic [1:0] POWER_SAVING_SELECT_O,
    input wire logic POWER_SAVING_ENABLE_O
);
    logic [15:0] last_q;
    logic crossing;
    // Last stored light value, to spot a downward crossing
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            last_q <= 16'h0000;
        end else if (MEAS_VALID_I) begin
            last_q <= AMBIENT_LIGHT_RESULT_I;
        end
    end
    assign crossing = MEAS_VALID_I && INT_ENABLE_I && last_q >= LOW_WINDOW_LIMIT_O
        && AMBIENT_LIGHT_RESULT_I < LOW_WINDOW_LIMIT_O;
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (RST_I);
    flag_set_a: assert property (crossing |-> ##[1:2] INT_STATUS_O[15])
        else $error("flag not raised after crossing");
    flag_cause_a: assert property ($rose(INT_STATUS_O[15]) |->
        ($past(MEAS_VALID_I) || $past(MEAS_VALID_I, 2)) && $past(INT_ENABLE_I))
        else $error("flag raised without measurement");
    flag_hold_a: assert property (INT_STATUS_O[15] && !FLAG_CLEAR_I |=> INT_STATUS_O[15])
        else $error("flag dropped without clear");
    status_rsvd_a: assert property (INT_STATUS_O[14:0] == 15'h0000)
        else $error("status low bits not zero");
    limit_write_a: assert property ($changed(LOW_WINDOW_LIMIT_O) |-> !$past(SCL_I, 8))
        else $error("limit changed outside a serial write");
    mode_write_a: assert property ($changed({POWER_SAVING_SELECT_O, POWER_SAVING_ENABLE_O})
        |-> !$past(SCL_I, 8))
        else $error("mode changed outside a serial write");
    data_timing_a: assert property ($changed(SDA_OE_O) |-> !SCL_I && !$past(SCL_I, 8))
        else $error("data line moved while clock high");
    drive_low_a: assert property (SDA_O == 1'b0)
        else $error("data driver not low");
    reset_vals_a: assert property ($fell(RST_I) |-> !SDA_OE_O && INT_STATUS_O == 16'h0000
        && LOW_WINDOW_LIMIT_O == 16'h0000 && !POWER_SAVING_ENABLE_O
        && POWER_SAVING_SELECT_O == 2'h0)
        else $error("outputs not cleared by reset");
    flag_c: cover property ($rose(INT_STATUS_O[15]));
    limit_c: cover property ($changed(LOW_WINDOW_LIMIT_O));
    ack_c: cover property ($rose(SDA_OE_O));
endmodule
bind lsrr_top lsrr_top_sva i_sva (
    .CORE_CLK_I(CORE_CLK_I),
    .RST_I(RST_I),
    .SCL_I(SCL_I),
    .SDA_I(SDA_I),
    .SDA_O(SDA_O),
    .SDA_OE_O(SDA_OE_O),
    .MEAS_VALID_I(MEAS_VALID_I),
    .AMBIENT_LIGHT_RESULT_I(AMBIENT_LIGHT_RESULT_I),
    .BROADBAND_RESULT_I(BROADBAND_RESULT_I),
    .INT_ENABLE_I(INT_ENABLE_I),
    .FLAG_CLEAR_I(FLAG_CLEAR_I),
    .INT_STATUS_O(INT_STATUS_O),
    .LOW_WINDOW_LIMIT_O(LOW_WINDOW_LIMIT_O),
    .POWER_SAVING_SELECT_O(POWER_SAVING_SELECT_O),
    .POWER_SAVING_ENABLE_O(POWER_SAVING_ENABLE_O)
);

// ==== verification/lsrr_top_tb.sv ====
`timescale 1ns/1ns
module lsrr_top_tb;
    logic clk;
    logic rst;
    logic meas;
    logic int_en;
    logic clr;
    logic scl;
    logic sda;
    logic sda_oe;
    logic ps_en;
    logic [1:0] sel;
    logic [15:0] amb;
    logic [15:0] brd;
    logic [15:0] status;
    logic [15:0] low;
    logic [15:0] rdat;
    int err_count = 0;
    int check_count = 0;
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin err_count++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
    lsrr_top i_dut (
        .CORE_CLK_I(clk), .RST_I(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(),
        .SDA_OE_O(sda_oe), .MEAS_VALID_I(meas), .AMBIENT_LIGHT_RESULT_I(amb),
        .BROADBAND_RESULT_I(brd), .INT_ENABLE_I(int_en), .FLAG_CLEAR_I(clr),
        .INT_STATUS_O(status), .LOW_WINDOW_LIMIT_O(low),
        .POWER_SAVING_SELECT_O(sel), .POWER_SAVING_ENABLE_O(ps_en)
    );
    lsrr_host i_host (.clk_i(clk), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task summarize();
        if (err_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task pulse(input logic [15:0] a, input logic [15:0] b);
        amb = a;
        brd = b;
        meas = 1'b1;
        @(negedge clk);
        meas = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    task t_low();
        i_host.wr(lsrr_pkg::CMD_LOW_LIMIT, 16'hA55A);
        `CHK("low limit", 16'hA55A, low);
        `CHK("acks", 0, i_host.nak);
        i_host.start();
        i_host.wbyte(8'h22);
        i_host.stop();
        `CHK("foreign address", 1, i_host.nak);
    endtask
    task t_ps();
        for (int i = 0; i < 4; i++) begin
            i_host.wr(lsrr_pkg::CMD_PS_CTRL, {13'h0, i[1:0], i[0]});
            `CHK("mode select", i[1:0], sel);
            `CHK("power save", i[0], ps_en);
        end
    endtask
    task t_read();
        pulse(16'h1234, 16'hABCD);
        fork
            i_host.rd(lsrr_pkg::CMD_LIGHT, rdat);
            begin
                @(i_host.latched);
                pulse(16'h5678, 16'h9999);
            end
        join
        `CHK("light word", 16'h1234, rdat);
        i_host.rd(lsrr_pkg::CMD_BROAD, rdat);
        `CHK("broad word", 16'h9999, rdat);
        i_host.rd(lsrr_pkg::CMD_LOW_LIMIT, rdat);
        `CHK("write-only word", 16'h0000, rdat);
        `CHK("read acks", 1, i_host.nak);
    endtask
    task t_flag();
        pulse(16'hFFFF, 16'h0001);
        pulse(16'h1000, 16'h0002);
        `CHK("flag off", 1'b0, status[15]);
        int_en = 1'b1;
        pulse(16'hFFFF, 16'h0003);
        pulse(16'h1000, 16'h0004);
        `CHK("flag set", 1'b1, status[15]);
        pulse(16'h0800, 16'h0005);
        `CHK("flag held", 1'b1, status[15]);
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        @(negedge clk);
        `CHK("flag clear", 1'b0, status[15]);
        pulse(16'hFFFF, 16'h0006);
        amb = 16'h1000;
        meas = 1'b1;
        clr = 1'b1;
        @(negedge clk);
        meas = 1'b0;
        clr = 1'b0;
        @(negedge clk);
        `CHK("set over clear", 1'b1, status[15]);
    endtask
    task t_reset();
        rst = 1'b1;
        @(negedge clk);
        `CHK("limit reset", lsrr_pkg::LOW_LIMIT_RST, low);
        `CHK("mode reset", 2'h0, sel);
        `CHK("enable reset", lsrr_pkg::PS_EN_RST, ps_en);
        `CHK("status reset", 16'h0000, status);
        rst = 1'b0;
        repeat (20) @(negedge clk);
    endtask
    initial begin
        rst = 1'b1;
        meas = 1'b0;
        int_en = 1'b0;
        clr = 1'b0;
        amb = 16'h0000;
        brd = 16'h0000;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (20) @(negedge clk);
        t_low();
        t_ps();
        t_read();
        t_flag();
        t_reset();
        summarize();
    end
    initial begin
        #400000;
        err_count++;
        summarize();
    end
endmodule
